// ### core/tcc_pkg.sv
// Purpose: shared constants and carriers of the timer counting core
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: offsets are byte addresses
package tcc_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] TCC_CTL_OFS = 8'h00;
    localparam logic [7:0] TCC_STAT_OFS = 8'h10;
    localparam logic [7:0] TCC_MASK_OFS = 8'h14;
    localparam logic [7:0] TCC_CHAN_OFS = 8'h20;
    localparam logic [7:0] TCC_CNT_OFS = 8'h24;
    localparam logic [7:0] TCC_DIV_OFS = 8'h28;
    localparam logic [7:0] TCC_RELOAD_OFS = 8'h2c;
    localparam logic [7:0] TCC_REPEAT_OFS = 8'h30;
    localparam logic [7:0] TCC_PROTECTION_LEVEL_OFS = 8'h44;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int TCC_CTL_RUN = 0;
    localparam int TCC_CTL_SHADOW = 1;
    localparam int TCC_CTL_OUTMODE = 2;
    localparam int TCC_ST_UPDATE = 0;
    localparam int TCC_ST_CAPTURE = 1;
    localparam int TCC_CHAN_POL = 1;
    localparam logic [15:0] TCC_RST16 = 16'h0000;
    localparam logic [7:0] TCC_RST8 = 8'h00;
    localparam logic [2:0] TCC_HSIZE_WORD = 3'h2;
    localparam logic [31:0] TCC_RDATA_NONE = 32'h0000_0000;

    // channel 0 enable and polarity bits, same order as the bus word
    typedef struct packed {
        logic comp_polarity;
        logic comp_out_en;
        logic polarity;
        logic enable;
    } tcc_chan_s;

    // latched address phase
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
    } tcc_aph_s;

endpackage

// ### core/tcc_sync.sv
// Purpose: two-stage synchroniser for a pin input
// Assumes: input is asynchronous to ref_clk_i
// Notes: only the second stage leaves this module
`timescale 1ns/10ps
module tcc_sync
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // data
    input wire logic din_i,
    output logic dout_o
);
    logic meta;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            dout_o <= 1'b0;
        end else begin
            meta <= din_i;
            dout_o <= meta;
        end
    end
endmodule

// ### core/tcc_prescale.sv
// Purpose: divides the kernel clock into counter ticks
// Assumes: div_i only changes while tick_o is high or at restart
// Notes: a tick every div_i + 1 kernel clocks while run_i is high
`timescale 1ns/10ps
module tcc_prescale
    import tcc_pkg::*;
#(
    parameter int W = 16
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // control
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic [W-1:0] div_i,
    // tick
    output logic tick_o
);
    logic [W-1:0] cnt;

    assign tick_o = run_i && (cnt == div_i);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || restart_i) begin
            cnt <= '0;
        end else if (tick_o) begin
            cnt <= '0;
        end else if (run_i) begin
            cnt <= cnt + 1'b1;
        end
    end

    // tick spacing
    tick_gap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (run_i && !restart_i && !tick_o) |=> (cnt == $past(cnt) + 1'b1))
        else $error("prescaler tick out of step");
endmodule

// ### core/tcc_top.sv
// Purpose: timer counting core with channel 0 enable and polarity controls
// Assumes: single 10 MHz kernel clock, AHB-Lite slave, word transfers only
// Notes: zero-wait-state slave; read data registered at the address phase
`timescale 1ns/10ps
module tcc_top
    import tcc_pkg::*;
#(
    parameter int CW = 16,
    parameter int RW = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // channel 0 pins
    input wire logic ch_zero_input_i,
    output logic ch_zero_output_o,
    output logic ch_zero_output_oe_o,
    output logic ch_zero_comp_output_o,
    output logic ch_zero_comp_output_oe_o,
    // events
    output logic filtered_input_edge_o,
    output logic irq_o
);

    // ****************************************
    // register state
    // ****************************************
    logic [2:0] ctl;
    tcc_chan_s chan;
    logic [1:0] protection_level;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic [CW-1:0] count_value;
    logic [CW-1:0] divider_value;
    logic [CW-1:0] divider_shadow;
    logic [CW-1:0] reload_value;
    logic [CW-1:0] reload_shadow;
    logic [RW-1:0] repeat_value;
    logic [RW-1:0] rep_cnt;
    logic out_ref;
    logic in_sync;
    logic in_prev;
    logic tick;
    logic wrap;
    logic upd;
    logic cap_evt;
    logic [CW-1:0] limit;
    tcc_aph_s aph;
    logic aph_valid;
    logic wr_en;
    logic [31:0] next_rdata;
    logic next_out;
    logic next_comp;

    // ****************************************
    // ahb-lite slave
    // ****************************************
    // word-only: narrower writes are dropped, software keeps to words
    logic addr_take;
    assign addr_take = hsel && htrans[1] && hready && (hsize == TCC_HSIZE_WORD);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            aph_valid <= 1'b0;
            aph <= '0;
        end else begin
            aph_valid <= addr_take;
            aph.wr <= hwrite;
            aph.addr <= haddr[7:0];
        end
    end

    assign wr_en = aph_valid && aph.wr;

    function automatic logic wr_to(input logic [7:0] ofs);
        wr_to = wr_en && (aph.addr == ofs);
    endfunction

    always_comb begin
        next_rdata = TCC_RDATA_NONE;
        unique case (haddr[7:0])
            TCC_CTL_OFS: next_rdata[2:0] = ctl;
            TCC_STAT_OFS: next_rdata[1:0] = int_status;
            TCC_MASK_OFS: next_rdata[1:0] = int_mask;
            TCC_CHAN_OFS: next_rdata[3:0] = chan;
            TCC_CNT_OFS: next_rdata[CW-1:0] = count_value;
            TCC_DIV_OFS: next_rdata[CW-1:0] = divider_value;
            TCC_RELOAD_OFS: next_rdata[CW-1:0] = reload_value;
            TCC_REPEAT_OFS: next_rdata[RW-1:0] = repeat_value;
            TCC_PROTECTION_LEVEL_OFS: next_rdata[1:0] = protection_level;
            default: next_rdata = TCC_RDATA_NONE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            hrdata <= TCC_RDATA_NONE;
        end else if (addr_take && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctl <= '0;
            int_mask <= '0;
            protection_level <= '0;
            divider_value <= TCC_RST16;
            reload_value <= TCC_RST16;
            repeat_value <= TCC_RST8;
        end else begin
            if (wr_to(TCC_CTL_OFS)) ctl <= hwdata[2:0];
            if (wr_to(TCC_MASK_OFS)) int_mask <= hwdata[1:0];
            if (wr_to(TCC_PROTECTION_LEVEL_OFS)) protection_level <= hwdata[1:0];
            if (wr_to(TCC_DIV_OFS)) divider_value <= hwdata[CW-1:0];
            if (wr_to(TCC_RELOAD_OFS)) reload_value <= hwdata[CW-1:0];
            if (wr_to(TCC_REPEAT_OFS)) repeat_value <= hwdata[RW-1:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            chan <= '0;
        end else if (wr_to(TCC_CHAN_OFS)) begin
            chan.comp_polarity <= hwdata[3];
            chan.comp_out_en <= hwdata[2];
            chan.enable <= hwdata[0];
            // polarity locked at levels 11 and 10
            if (!protection_level[1]) chan.polarity <= hwdata[TCC_CHAN_POL];
        end
    end

    protection_level_lock_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_to(TCC_CHAN_OFS) && protection_level[1]) |=> $stable(chan.polarity))
        else $error("polarity changed under protection");

    // ****************************************
    // counter, prescaler and repetition
    // ****************************************
    tcc_prescale #(
        .W(CW)
    ) u_prescale (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .run_i(ctl[TCC_CTL_RUN]),
        .restart_i(wr_to(TCC_CNT_OFS)),
        .div_i(divider_shadow),
        .tick_o(tick)
    );

    assign limit = ctl[TCC_CTL_SHADOW] ? reload_shadow : reload_value;
    // wrap once the limit is reached
    assign wrap = tick && (count_value >= limit);
    // update only when repetition reaches zero
    assign upd = wrap && (rep_cnt == '0);

    // a write replaces the running count
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_value <= TCC_RST16;
        end else if (wr_to(TCC_CNT_OFS)) begin
            count_value <= hwdata[CW-1:0];
        end else if (wrap) begin
            count_value <= '0;
        end else if (tick) begin
            count_value <= count_value + 1'b1;
        end
    end

    // each wrap steps the repetition counter down, or reloads it from repeat_value when it is zero
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rep_cnt <= TCC_RST8;
        end else if (upd) begin
            rep_cnt <= repeat_value;
        end else if (wrap) begin
            rep_cnt <= rep_cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            divider_shadow <= TCC_RST16;
            reload_shadow <= TCC_RST16;
        end else if (upd) begin
            divider_shadow <= divider_value;
            reload_shadow <= reload_value;
        end
    end

    sequence wrap_nz_s;
        wrap && (rep_cnt != '0) && !upd;
    endsequence

    rep_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wrap_nz_s |=> (rep_cnt == $past(rep_cnt) - 1'b1))
        else $error("repetition counter did not step");

    cnt_wrap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wrap && !wr_to(TCC_CNT_OFS)) |=> (count_value == '0))
        else $error("counter did not wrap at limit");

    cnt_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wr_to(TCC_CNT_OFS) |=> (count_value == $past(hwdata[CW-1:0])))
        else $error("counter write lost");

    div_shadow_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !upd |=> $stable(divider_shadow))
        else $error("divider shadow changed outside update");

    reload_shadow_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        upd |=> (reload_shadow == $past(reload_value)))
        else $error("reload shadow not refreshed at update");

    // ****************************************
    // channel 0 input path
    // ****************************************
    tcc_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .din_i(ch_zero_input_i),
        .dout_o(in_sync)
    );

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            in_prev <= 1'b0;
        end else begin
            in_prev <= in_sync;
        end
    end

    // edges taken on the raw level so a polarity change makes no false edge
    logic in_rise;
    logic in_fall;
    assign in_rise = in_sync && !in_prev;
    assign in_fall = !in_sync && in_prev;

    always_comb begin
        unique case ({chan.comp_polarity, chan.polarity})
            2'b00: filtered_input_edge_o = in_rise;
            2'b01: filtered_input_edge_o = in_fall;
            // both edges; reserved code acts as rising
            2'b11: filtered_input_edge_o = in_rise || in_fall;
            2'b10: filtered_input_edge_o = in_rise;
        endcase
    end

    // capture only while enabled in input mode
    assign cap_evt = filtered_input_edge_o && chan.enable && !ctl[TCC_CTL_OUTMODE];

    sequence in_fall_s;
        $past(in_sync) && !in_sync;
    endsequence

    edge_fall_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (({chan.comp_polarity, chan.polarity} == 2'b01) ##0 in_fall_s)
            |-> filtered_input_edge_o)
        else $error("falling edge missed when inverted");

    edge_both_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (($past(in_sync) != in_sync) && chan.comp_polarity && chan.polarity)
            |-> filtered_input_edge_o)
        else $error("edge missed in both-edge mode");

    edge_rise_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (({chan.comp_polarity, chan.polarity} == 2'b00) && filtered_input_edge_o)
            |-> (in_sync && $past(in_sync) == 1'b0))
        else $error("non-rising edge accepted");

    // ****************************************
    // channel 0 output path
    // ****************************************
    // reference toggles at each update, one full cycle per two updates
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            out_ref <= 1'b0;
        end else if (upd) begin
            out_ref <= !out_ref;
        end
    end

    assign next_out = out_ref ^ chan.polarity;
    assign next_comp = !out_ref ^ chan.comp_polarity;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ch_zero_output_o <= 1'b0;
            ch_zero_output_oe_o <= 1'b0;
            ch_zero_comp_output_o <= 1'b0;
            ch_zero_comp_output_oe_o <= 1'b0;
        end else begin
            ch_zero_output_oe_o <= ctl[TCC_CTL_OUTMODE] && chan.enable;
            ch_zero_output_o <= chan.enable ? next_out : chan.polarity;
            // complementary output gated by its enable
            ch_zero_comp_output_oe_o <= ctl[TCC_CTL_OUTMODE] && chan.comp_out_en;
            ch_zero_comp_output_o <= chan.comp_out_en ? next_comp : chan.comp_polarity;
        end
    end

    comp_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !chan.comp_out_en |=> !ch_zero_comp_output_oe_o)
        else $error("complementary output driven while disabled");

    out_level_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ctl[TCC_CTL_OUTMODE] && chan.enable)
            |=> ch_zero_output_oe_o && (ch_zero_output_o == ($past(out_ref) ^ $past(chan.polarity))))
        else $error("main output level wrong");

    // ****************************************
    // interrupts
    // ****************************************
    // set wins over a write-one clear in the same cycle
    logic [1:0] st_set;
    logic [1:0] st_clr;
    assign st_set = {cap_evt, upd};
    assign st_clr = wr_to(TCC_STAT_OFS) ? hwdata[1:0] : 2'b00;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            int_status <= '0;
        end else begin
            int_status <= (int_status & ~st_clr) | st_set;
        end
    end

    assign irq_o = |(int_status & int_mask);

    cap_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cap_evt |=> int_status[TCC_ST_CAPTURE])
        else $error("capture event not flagged");

    upd_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        upd |=> int_status[TCC_ST_UPDATE] ##1 (irq_o || !int_mask[TCC_ST_UPDATE]
            || !int_status[TCC_ST_UPDATE]))
        else $error("update event not flagged");

endmodule

// ### test/tb_timer_count_core_ch0_enable.sv
// Purpose: self-checking bench for the timer counting core
// Assumes: zero-wait AHB-Lite slave, hready tied to hreadyout
// Notes: bus reads are scored from a queue by a separate watcher
`timescale 1ns/10ps
module tb_timer_count_core_ch0_enable import tcc_pkg::*;;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic ch_zero_input_i = 1'b0;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic out_o, out_oe, comp_o, comp_oe, edge_o, irq_o;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    int edge_n = 0;
    logic rd_dp = 1'b0;
    logic out_prev = 1'b0;
    logic [31:0] exp_q[$];
    int tog_q[$];

    tcc_top #(.CW(16), .RW(8)) tcc_top_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ch_zero_input_i(ch_zero_input_i), .ch_zero_output_o(out_o),
        .ch_zero_output_oe_o(out_oe), .ch_zero_comp_output_o(comp_o),
        .ch_zero_comp_output_oe_o(comp_oe), .filtered_input_edge_o(edge_o), .irq_o(irq_o));

    always #50 ref_clk_i = ~ref_clk_i;

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watcher: read data scored at the data-phase edge, pulses and toggles logged
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (rd_dp && hreadyout) begin
            if (exp_q.size() == 0) begin
                check(hrdata, 32'hdead_beef);
            end else begin
                check(hrdata, exp_q.pop_front());
            end
            check({31'h0, hresp}, 32'h0);
        end
        if (hreadyout) begin
            rd_dp <= hsel && htrans[1] && !hwrite;
        end
        if (edge_o === 1'b1) begin
            edge_n <= edge_n + 1;
        end
        if (out_o !== out_prev) begin
            tog_q.push_back(cyc);
        end
        out_prev <= out_o;
        if (cyc > 20000) begin
            err_total++;
            print_verdict();
        end
    end

    // ****************************************
    // bus master
    // ****************************************
    task automatic wait_rdy();
        @(posedge ref_clk_i);
        while (hreadyout !== 1'b1) begin
            @(posedge ref_clk_i);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        @(posedge ref_clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        hsize <= TCC_HSIZE_WORD;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wr ? wd : 32'h0;
        wait_rdy();
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
        bus(1'b1, ofs, wd);
    endtask

    task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, ofs, 32'h0);
    endtask

    task automatic wait_tog(input int k);
        int n;
        n = 0;
        while (tog_q.size() < k && n < 3000) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (tog_q.size() < k) begin
            check(tog_q.size(), k);
            print_verdict();
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [7:0] ofs_t[6];
        logic [3:0] c;
        logic [31:0] v;
        int e0;
        int er[3];
        int ef[3];
        ofs_t = '{TCC_CNT_OFS, TCC_DIV_OFS, TCC_RELOAD_OFS, TCC_REPEAT_OFS, TCC_CHAN_OFS,
                  TCC_CTL_OFS};
        er = '{1, 0, 1};
        ef = '{0, 1, 1};
        void'($urandom(86245));
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) rd(ofs_t[i], 32'h0);
        wr(TCC_CTL_OFS, 32'h4);
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            wr(TCC_CHAN_OFS, {28'h0, c});
            repeat (2) @(posedge ref_clk_i);
            check({31'h0, out_oe}, {31'h0, c[0]});
            check({31'h0, out_o}, {31'h0, c[1]});
            check({31'h0, comp_oe}, {31'h0, c[2]});
            check({31'h0, comp_o}, {31'h0, c[3] ^ c[2]});
            rd(TCC_CHAN_OFS, {28'h0, c});
        end
        wr(TCC_CTL_OFS, 32'h0);
        repeat (2) @(posedge ref_clk_i);
        check({30'h0, out_oe, comp_oe}, 32'h0);
        for (int p = 0; p < 4; p++) begin
            wr(TCC_PROTECTION_LEVEL_OFS, 32'h0);
            wr(TCC_CHAN_OFS, 32'h0);
            wr(TCC_PROTECTION_LEVEL_OFS, p);
            wr(TCC_CHAN_OFS, 32'h2);
            rd(TCC_CHAN_OFS, (p >= 2) ? 32'h0 : 32'h2);
        end
        wr(TCC_PROTECTION_LEVEL_OFS, 32'h0);
        // active input edges with capture interrupt
        wr(TCC_STAT_OFS, 32'h3);
        wr(TCC_MASK_OFS, 32'h2);
        for (int i = 0; i < 3; i++) begin
            wr(TCC_CHAN_OFS, (i == 2 ? 32'h8 : 32'h0) | (i > 0 ? 32'h2 : 32'h0) | 32'h1);
            repeat (2) @(posedge ref_clk_i);
            e0 = edge_n;
            ch_zero_input_i <= 1'b1;
            repeat (6) @(posedge ref_clk_i);
            check(edge_n - e0, er[i]);
            e0 = edge_n;
            ch_zero_input_i <= 1'b0;
            repeat (6) @(posedge ref_clk_i);
            check(edge_n - e0, ef[i]);
            rd(TCC_STAT_OFS, 32'h2);
            check({31'h0, irq_o}, 32'h1);
            wr(TCC_STAT_OFS, 32'h2);
            repeat (2) @(posedge ref_clk_i);
            check({31'h0, irq_o}, 32'h0);
        end
        // masked capture, then a disabled channel captures nothing
        wr(TCC_CHAN_OFS, 32'h1);
        wr(TCC_MASK_OFS, 32'h0);
        ch_zero_input_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        check({31'h0, irq_o}, 32'h0);
        rd(TCC_STAT_OFS, 32'h2);
        wr(TCC_MASK_OFS, 32'h2);
        repeat (2) @(posedge ref_clk_i);
        check({31'h0, irq_o}, 32'h1);
        wr(TCC_STAT_OFS, 32'h2);
        ch_zero_input_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        wr(TCC_CHAN_OFS, 32'h0);
        e0 = edge_n;
        ch_zero_input_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        check(edge_n - e0, 1);
        rd(TCC_STAT_OFS, 32'h0);
        // word writes, upper bits kept zero
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            wr(TCC_CNT_OFS, v & 32'hffff);
            rd(TCC_CNT_OFS, v & 32'hffff);
            wr(TCC_DIV_OFS, v & 32'hffff);
            rd(TCC_DIV_OFS, v & 32'hffff);
            wr(TCC_RELOAD_OFS, v & 32'hffff);
            rd(TCC_RELOAD_OFS, v & 32'hffff);
            wr(TCC_REPEAT_OFS, v & 32'hff);
            rd(TCC_REPEAT_OFS, v & 32'hff);
            wr(8'h08, v);
            rd(8'h08, 32'h0);
        end
        wr(TCC_DIV_OFS, 32'h2);
        wr(TCC_RELOAD_OFS, 32'h4);
        wr(TCC_REPEAT_OFS, 32'h1);
        wr(TCC_CHAN_OFS, 32'h1);
        tog_q.delete();
        wr(TCC_CTL_OFS, 32'h5);
        wait_tog(3);
        check(tog_q[2] - tog_q[1], 30);
        // shadowed values wait for the next update
        wr(TCC_CTL_OFS, 32'h7);
        wait_tog(4);
        wr(TCC_DIV_OFS, 32'h1);
        wr(TCC_RELOAD_OFS, 32'h2);
        wait_tog(6);
        check(tog_q[4] - tog_q[3], 30);
        check(tog_q[5] - tog_q[4], 12);
        wr(TCC_REPEAT_OFS, 32'h0);
        wait_tog(8);
        check(tog_q[7] - tog_q[6], 6);
        rd(TCC_STAT_OFS, 32'h1);
        wr(TCC_MASK_OFS, 32'h1);
        repeat (2) @(posedge ref_clk_i);
        check({31'h0, irq_o}, 32'h1);
        repeat (3) @(posedge ref_clk_i);
        check(exp_q.size(), 0);
        print_verdict();
    end
endmodule
